// file: kli_keypad.sv
/*
  Keypad level interrupt: eight port lines with level select, enable
  mask and read-clear flags on the special function register bus.
  Assumes a core that asserts sfr_rd_in / sfr_wr_in for one cycle per
  access; a system-level interrupt enable bit lives in the core's second
  interrupt-enable register and arrives as a plain input.
*/
`timescale 1ns/1ps
`default_nettype none

module kli_keypad (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // Special function register bus
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  // Global enable from the second interrupt-enable register
  input wire logic keypad_global_irq_enable_in,
  // Port pins
  input wire logic [7:0] port_pins_in,
  // Status to the core
  output logic keypad_irq_out,
  output logic keypad_wake_out,
  output logic [7:0] keypad_line_enable_out
);

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0] keypad_level_select_reg;
  logic [7:0] keypad_line_enable_reg;
  logic [7:0] rdata_reg;
  logic hit_reg;
  logic irq_reg;
  logic wake_reg;
  logic [7:0] rdata_next;
  wire logic [7:0] keypad_line_flags;
  wire logic [7:0] line_match;
  wire logic sel_level;
  wire logic sel_enable;
  wire logic sel_flags;
  wire logic flags_clear;
  wire logic irq_next;
  wire logic wake_next;
  wire logic wr_level;
  wire logic wr_enable;
  wire logic rd_mapped;

  // Address decode
  assign sel_level = (sfr_addr_in == kli_pkg::ADDR_LEVEL_SELECT);
  assign sel_enable = (sfr_addr_in == kli_pkg::ADDR_LINE_ENABLE);
  assign sel_flags = (sfr_addr_in == kli_pkg::ADDR_LINE_FLAGS);

  assign flags_clear = sfr_rd_in & sel_flags;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (sel_level) begin
      rdata_next = keypad_level_select_reg;
    end else if (sel_enable) begin
      rdata_next = keypad_line_enable_reg;
    end else if (sel_flags) begin
      rdata_next = keypad_line_flags;
    end
  end

  // ----------------------------------------------------------------
  // Per-line detectors
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < kli_pkg::LINES; gi++) begin : g_line
      kli_line_detect u_det (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .clk_en_in(clk_en_in),
        .pin_in(port_pins_in[gi]),
        .level_sel_in(keypad_level_select_reg[gi]),
        .flag_clear_in(flags_clear),
        .flag_out(keypad_line_flags[gi]),
        .match_out(line_match[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt and wake
  // ----------------------------------------------------------------
  // enable masks each flag
  assign irq_next = keypad_global_irq_enable_in &
                    (|(keypad_line_flags & keypad_line_enable_reg));

  // wake from live level
  // Uses the live match, not the sticky flag, so wake drops once
  // the key is let go and a stale flag cannot hold the core awake
  assign wake_next = |(line_match & keypad_line_enable_reg);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Write strobes; the flag register takes no write, so a store
  // aimed at it simply falls through
  assign wr_level = sfr_wr_in & sel_level;
  assign wr_enable = sfr_wr_in & sel_enable;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      keypad_level_select_reg <= kli_pkg::RST_LEVEL_SELECT;
    end else if (clk_en_in && wr_level) begin
      keypad_level_select_reg <= sfr_wdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      keypad_line_enable_reg <= kli_pkg::RST_LINE_ENABLE;
    end else if (clk_en_in && wr_enable) begin
      keypad_line_enable_reg <= sfr_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  // Only the three mapped addresses answer a read
  assign rd_mapped = sfr_rd_in & (sel_level | sel_enable | sel_flags);

  // Read data shows the flags before the clear lands, and holds
  // between reads so a slow core may pick it up late
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= kli_pkg::RST_LINE_FLAGS;
    end else if (clk_en_in && sfr_rd_in) begin
      rdata_reg <= rdata_next;
    end
  end

  // Hit pulse, one cycle per mapped read
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hit_reg <= 1'b0;
    end else if (clk_en_in) begin
      hit_reg <= rd_mapped;
    end
  end

  // ----------------------------------------------------------------
  // Request and wake registers
  // ----------------------------------------------------------------
  // Registered so the request toward the core is glitch free
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_reg <= 1'b0;
    end else if (clk_en_in) begin
      irq_reg <= irq_next;
    end
  end

  // Wake level, frozen with the rest while the clock enable is low
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wake_reg <= 1'b0;
    end else if (clk_en_in) begin
      wake_reg <= wake_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flop, so the core sees no decode glitches

  assign sfr_rdata_out = rdata_reg;
  assign sfr_hit_out = hit_reg;
  assign keypad_irq_out = irq_reg;
  assign keypad_wake_out = wake_reg;
  assign keypad_line_enable_out = keypad_line_enable_reg;

endmodule

`default_nettype wire

// file: kli_keypad_monitor.sv
/* Port checker for the keypad block.
   Assumes one clock domain, reset active low. */
`timescale 1ns/1ps
`default_nettype none
module kli_keypad_monitor (
  // Clock, reset and enable
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // Register bus
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic keypad_global_irq_enable_in,
  // Status
  input wire logic [7:0] keypad_line_enable_out,
  input wire logic sfr_hit_out,
  input wire logic keypad_irq_out,
  input wire logic keypad_wake_out
);
  // ----------
  // Relations
  // ----------
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Strobes count only on enabled edges
  wire logic rd = sfr_rd_in && clk_en_in;
  wire logic wr = sfr_wr_in && clk_en_in;
  wire logic irq = keypad_irq_out;
  wire logic glob = keypad_global_irq_enable_in;
  wire logic en0 = keypad_line_enable_out == 8'h00;
  property p_rd; rd && sfr_addr_in == kli_pkg::ADDR_LINE_FLAGS
    |=> sfr_hit_out; endproperty
  a_rd: assert property (p_rd) else $error("no hit");
  property p_quiet; clk_en_in && !sfr_rd_in |=> !sfr_hit_out; endproperty
  a_quiet: assert property (p_quiet) else $error("stray hit");
  property p_wr; wr && sfr_addr_in == kli_pkg::ADDR_LINE_ENABLE
    |=> keypad_line_enable_out == $past(sfr_wdata_in); endproperty
  a_wr: assert property (p_wr) else $error("enable lost");
  property p_rst; $rose(rst_b_in)
    |-> en0 && !irq && !keypad_wake_out && !sfr_hit_out; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_mask; en0 && clk_en_in |=> !irq; endproperty
  a_mask: assert property (p_mask) else $error("unmasked");
  property p_glob; !glob && clk_en_in |=> !irq; endproperty
  a_glob: assert property (p_glob) else $error("global off");
  property p_wake; en0 && clk_en_in |=> !keypad_wake_out; endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_irq; irq && $past(clk_en_in) |-> $past(glob) && !$past(en0);
  endproperty
  a_irq: assert property (p_irq) else $error("irq cause");
  // Flags are sticky, so the request holds
  property p_hold; irq && glob && !$past(rd) && $past(clk_en_in)
    && $stable(keypad_line_enable_out) |=> irq; endproperty
  a_hold: assert property (p_hold) else $error("irq drop");
endmodule
bind kli_keypad kli_keypad_monitor mon (.*);
`default_nettype wire

// file: kli_keys.sv
/* Keypad switch model on the port pins.
   Assumes pull-ups: a pressed key pulls its line low. */
`timescale 1ns/1ps
`default_nettype none
module kli_keys (
  // Keys and pins
  input wire logic [7:0] press_in,
  output logic [7:0] pins_out
);
  // Released lines float up to the pull-up level
  assign pins_out = ~press_in;
endmodule
`default_nettype wire

// file: kli_line_detect.sv
/*
  One keypad line: pin synchroniser, level compare and sticky flag.
  Assumes the pin is asynchronous and the clear comes from the
  register decode on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module kli_line_detect (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // Line
  input wire logic pin_in,
  input wire logic level_sel_in,
  input wire logic flag_clear_in,
  // Result
  output logic flag_out,
  output logic match_out
);

  logic [1:0] sync_reg;
  logic flag_reg;
  logic flag_next;
  wire logic pin_sync;
  wire logic level_hit;

  // ----------------------------------------------------------------
  // Synchroniser; reset high, matching idle pulled-up port pins
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_reg <= kli_pkg::RST_SYNC;
    end else if (clk_en_in) begin
      sync_reg <= {sync_reg[0], pin_in};
    end
  end

  assign pin_sync = sync_reg[1];

  assign level_hit = (pin_sync == level_sel_in);

  assign flag_next = level_hit | (flag_reg & ~flag_clear_in);

  // Flag store
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_reg <= 1'b0;
    end else if (clk_en_in) begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;
  assign match_out = level_hit;

endmodule

`default_nettype wire

// file: kli_pkg.sv
/*
  Constants for the keypad level interrupt block: special function
  register addresses, reset values and widths.
  Assumes an 8-bit special function register bus from the core.
*/
package kli_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int LINES = 8;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LEVEL_SELECT = 8'h9C;
  localparam logic [7:0] ADDR_LINE_ENABLE = 8'h9D;
  localparam logic [7:0] ADDR_LINE_FLAGS = 8'h9E;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LEVEL_SELECT = 8'h00;
  localparam logic [7:0] RST_LINE_ENABLE = 8'h00;
  localparam logic [7:0] RST_LINE_FLAGS = 8'h00;
  localparam logic [1:0] RST_SYNC = 2'h3;

endpackage

// file: test_keypad_level_interrupt.sv
/* Bench: register rows, then line cases.
   Assumes the switch model on the pins. */
`timescale 1ns/1ps
`default_nettype none
module test_keypad_level_interrupt;
  // ----------
  // Signals
  // ----------
  logic clock_in, rst_b_in, clk_en_in, sfr_wr_in, sfr_rd_in, sfr_hit_out;
  logic keypad_global_irq_enable_in, keypad_irq_out, keypad_wake_out;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, port_pins_in;
  logic [7:0] keypad_line_enable_out, press;
  wire logic [7:0] st = {6'h00, keypad_irq_out, keypad_wake_out};
  int bad_count = 0;
  int compares = 0;
  // Rows: write flag, address, data, expected read
  logic [31:0] rows [7] = '{32'h009C0000, 32'h009D0000, 32'h009E0000,
    32'h019EFF00, 32'h0155FF00, 32'h019D3C3C, 32'h019CA5A5};
  kli_keypad uut (.*);
  kli_keys keys (.press_in(press), .pins_out(port_pins_in));
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // Tests take about 75 cycles; the timeout fires at 800
  initial begin
    #20000;
    bad_count++;
    final_report;
  end
  task automatic chk(input logic [7:0] g, e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  // Optional write, then read back the same address
  task automatic acc(input logic [31:0] r);
    logic [7:0] hit_exp;
    sfr_addr_in = r[23:16];
    sfr_wdata_in = r[15:8];
    sfr_wr_in = r[24];
    @(posedge clock_in) #1;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b1;
    @(posedge clock_in) #1;
    sfr_rd_in = 1'b0;
    // A mapped read answers with a hit, unless the clock is frozen
    hit_exp = {7'h00, clk_en_in && (r[23:16] == kli_pkg::ADDR_LEVEL_SELECT
      || r[23:16] == kli_pkg::ADDR_LINE_ENABLE
      || r[23:16] == kli_pkg::ADDR_LINE_FLAGS)};
    chk(sfr_rdata_out, r[7:0]);
    chk({7'h00, sfr_hit_out}, hit_exp);
    if (r[23:16] == kli_pkg::ADDR_LINE_ENABLE) begin
      chk(keypad_line_enable_out, r[7:0]);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic final_report;
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {rst_b_in, sfr_rd_in, sfr_wr_in, sfr_addr_in, sfr_wdata_in} = '0;
    {keypad_global_irq_enable_in, press} = '0;
    clk_en_in = 1'b1;
    gap(3);
    rst_b_in = 1'b1;
    foreach (rows[i]) acc(rows[i]);
    acc(32'h009E00A5);
    acc(32'h019C0000);
    acc(32'h009E00A5);
    acc(32'h009E0000);
    acc(32'h019D0101);
    keypad_global_irq_enable_in = 1'b1;
    press = 8'h01;
    gap(6);
    chk(st, 8'h03);
    acc(32'h009E0001);
    acc(32'h009E0001);
    keypad_global_irq_enable_in = 1'b0;
    gap(2);
    chk(st, 8'h01);
    keypad_global_irq_enable_in = 1'b1;
    press = 8'h00;
    gap(6);
    acc(32'h009E0001);
    acc(32'h009E0000);
    gap(2);
    chk(st, 8'h00);
    acc(32'h019D0000);
    press = 8'h01;
    gap(6);
    chk(st, 8'h00);
    // Frozen clock enable: write lost, read data and hit hold
    clk_en_in = 1'b0;
    acc(32'h019DFF00);
    clk_en_in = 1'b1;
    acc(32'h009D0000);
    // Mid-run reset returns every mapped register to zero
    press = 8'h00;
    acc(32'h019C5A5A);
    acc(32'h019DC3C3);
    rst_b_in = 1'b0;
    gap(2);
    rst_b_in = 1'b1;
    chk(st, 8'h00);
    acc(32'h009C0000);
    acc(32'h009D0000);
    acc(32'h009E0000);
    final_report;
  end
endmodule
`default_nettype wire
